// *** hw/cdm_data_map.sv ***
// Data-memory addressing for an 8-bit core: register banks, bit area,
// stack pointer, page register and the on-chip external-data RAM.
// Assumes the execution unit issues at most one operation per cycle.
// Assumes the register port and the operations share one clock domain.
//
// Summary of operation
// RQ1: Bytes 0x00 to 0x1F form four banks of eight working registers.
// RQ2: Exactly one bank is active, picked by status word bits 3 and 4.
// RQ3: Register n of bank b sits at data address eight times b plus n.
// RQ4: Indirect modes take their pointer only from bank register zero or one.
// RQ5: Bytes 0x20 to 0x2F also act as 128 single bits 0x00 to 0x7F.
// RQ6: Bit address is eight times (byte minus 0x20) plus bit position.
// RQ7: Bit operations touch one bit; byte operations touch the whole byte.
// RQ8: Push writes at pointer plus one, then the pointer increments.
// RQ9: Every reset loads the stack pointer with 0x07.
// RQ10: The stack may sit anywhere in 256 bytes and span all of them.
// RQ11: Reset leaves data memory unchanged; only the pointer returns. The code also resets the status word and the page register.
// RQ12: 1024 bytes of external-data RAM, reached by pointer or register.
// RQ13: Register-indirect external moves take the high byte from the page.
// RQ14: Wide-pointer external moves ignore upper address bits and alias.
`timescale 1ns/100ps
module cdm_data_map
  import cdm_pkg::*;
#(
  parameter int unsigned XRAM_BYTES = XRAM_BYTES_DEF
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // Operation request from the execution unit.
  input cdm_op_t op_code,
  input wire logic [7:0] op_addr,
  input wire logic [2:0] op_reg,
  input wire logic [7:0] op_wdata,
  input wire logic op_wbit,
  input wire logic [15:0] op_xptr,
  // Operation answer.
  output logic op_done_q,
  output logic [7:0] op_rdata_q,
  output logic op_rbit_q,
  output logic op_bad_q,
  // State seen by the core.
  output logic [1:0] bank_q,
  output logic [7:0] stack_pointer_q
);

  localparam int unsigned XA_W = $clog2(XRAM_BYTES);

  ////////////////////////////////////////////////////////////////////////////
  // The page byte plus an 8-bit offset must cover the RAM, and the RAM
  // must be a power of two so that address bits can simply be dropped.
  if (XRAM_BYTES != (1 << XA_W) || XA_W < 8 || XA_W > 16) begin : g_bad_xram
    $error("cdm_data_map: XRAM_BYTES must be a power of two, 256 to 65536");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal data memory and the registers that steer it.
  logic [7:0] idata_q [IDATA_BYTES];
  logic [7:0] program_status_word_q;
  logic [7:0] program_status_word_d;
  logic [7:0] stack_pointer_d;
  logic [7:0] xram_page_control_q;
  logic [7:0] xram_page_control_d;
  logic [7:0] reg_rdata_d;
  logic op_done_d;
  logic [7:0] op_rdata_d;
  logic op_rbit_d;
  logic op_bad_d;
  logic [1:0] bank_d;

  // Write port of the internal memory, computed below.
  logic mem_we;
  logic [7:0] mem_idx;
  logic [7:0] mem_wd;

  // Address helpers.
  logic [1:0] bank_sel;
  logic [7:0] bank_reg_idx;
  logic [7:0] ptr_reg_idx;
  logic [7:0] ptr_val;
  logic [7:0] bit_byte_idx;
  logic [2:0] bit_pos;
  logic bit_in_area;
  logic [7:0] bit_byte_val;
  logic [7:0] bit_mask;
  logic [7:0] stack_up;
  logic [15:0] xri_full;

  cdm_xram_if #(.AW(XA_W)) xbus ();

  ////////////////////////////////////////////////////////////////////////////
  // Address formation.

  // One bank at a time, taken straight from the two status bits.
  assign bank_sel = {program_status_word_q[STATUS_BANK_HI],
                     program_status_word_q[STATUS_BANK_LO]}; // [RQ2]

  // Bank registers live in the lowest 32 bytes, eight per bank.
  assign bank_reg_idx = {3'b000, bank_sel, op_reg};           // [RQ1] [RQ3]

  // Only bank registers zero and one can serve as pointers.
  assign ptr_reg_idx = {3'b000, bank_sel, 2'b00, op_reg[0]};  // [RQ4]
  assign ptr_val = idata_q[ptr_reg_idx];

  // Bit address splits into byte offset from the area base and position.
  assign bit_in_area = ~op_addr[BIT_ADDR_HI];                 // [RQ5]
  assign bit_byte_idx = BIT_AREA_BASE + {4'h0, op_addr[6:3]}; // [RQ6]
  assign bit_pos = op_addr[2:0];                              // [RQ6]
  assign bit_byte_val = idata_q[bit_byte_idx];
  assign bit_mask = BIT_ONE << bit_pos;

  // The pointer wraps at 256, so the stack may span the whole memory.
  // No overflow flag is kept: software owns the depth budget.
  assign stack_up = stack_pointer_q + STACK_STEP;             // [RQ10]

  // Register-indirect external address takes its high byte from the page.
  // Only the low page bits reach the RAM; the rest are ignored.
  assign xri_full = {xram_page_control_q, ptr_val};           // [RQ13]

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for operations and the register port.
  always_comb begin
    mem_we = 1'b0;
    mem_idx = op_addr;
    mem_wd = op_wdata;
    xbus.we = 1'b0;
    xbus.addr = op_xptr[XA_W-1:0];
    xbus.wdata = op_wdata;
    stack_pointer_d = stack_pointer_q;
    program_status_word_d = program_status_word_q;
    xram_page_control_d = xram_page_control_q;
    op_done_d = 1'b0;
    op_rdata_d = op_rdata_q;
    op_rbit_d = op_rbit_q;
    op_bad_d = 1'b0;
    reg_rdata_d = RDATA_IDLE;

    case (op_code)
      OP_DIR_RD: begin
        op_rdata_d = idata_q[op_addr];
        op_done_d = 1'b1;
      end
      OP_DIR_WR: begin
        mem_we = 1'b1;
        op_done_d = 1'b1;
      end
      OP_BIT_RD: begin
        // Only the addressed bit is returned, never the whole byte.
        if (bit_in_area) begin
          op_rbit_d = bit_byte_val[bit_pos];                  // [RQ7]
        end else begin
          op_bad_d = 1'b1;
        end
        op_done_d = 1'b1;
      end
      OP_BIT_WR: begin
        // Read-modify-write keeps the other seven bits of the byte.
        if (bit_in_area) begin
          mem_we = 1'b1;
          mem_idx = bit_byte_idx;
          mem_wd = (bit_byte_val & ~bit_mask) |
                   (op_wbit ? bit_mask : 8'h00);              // [RQ7]
        end else begin
          op_bad_d = 1'b1;
        end
        op_done_d = 1'b1;
      end
      OP_REG_RD: begin
        op_rdata_d = idata_q[bank_reg_idx];                   // [RQ3]
        op_done_d = 1'b1;
      end
      OP_REG_WR: begin
        mem_we = 1'b1;
        mem_idx = bank_reg_idx;                               // [RQ3]
        op_done_d = 1'b1;
      end
      OP_IND_RD: begin
        op_rdata_d = idata_q[ptr_val];                        // [RQ4]
        op_done_d = 1'b1;
      end
      OP_IND_WR: begin
        mem_we = 1'b1;
        mem_idx = ptr_val;                                    // [RQ4]
        op_done_d = 1'b1;
      end
      OP_PUSH: begin
        // Write above the pointer and move it, so it names the last byte.
        mem_we = 1'b1;
        mem_idx = stack_up;                                   // [RQ8]
        stack_pointer_d = stack_up;                           // [RQ8]
        op_done_d = 1'b1;
      end
      OP_POP: begin
        op_rdata_d = idata_q[stack_pointer_q];
        stack_pointer_d = stack_pointer_q - STACK_STEP;       // [RQ10]
        op_done_d = 1'b1;
      end
      OP_XDP_RD: begin
        // Upper pointer bits are dropped, so the RAM repeats every block.
        xbus.addr = op_xptr[XA_W-1:0];                        // [RQ12] [RQ14]
        op_rdata_d = xbus.rdata;
        op_done_d = 1'b1;
      end
      OP_XDP_WR: begin
        xbus.we = 1'b1;
        xbus.addr = op_xptr[XA_W-1:0];                        // [RQ12] [RQ14]
        op_done_d = 1'b1;
      end
      OP_XRI_RD: begin
        xbus.addr = xri_full[XA_W-1:0];                       // [RQ12] [RQ13]
        op_rdata_d = xbus.rdata;
        op_done_d = 1'b1;
      end
      OP_XRI_WR: begin
        xbus.we = 1'b1;
        xbus.addr = xri_full[XA_W-1:0];                       // [RQ12] [RQ13]
        op_done_d = 1'b1;
      end
      default: begin
        // Idle cycle: nothing is written and no answer is given.
        op_done_d = 1'b0;
      end
    endcase

    // Software writes come after the operation, so a register write in
    // the same cycle as a push or pop decides the pointer.
    if (reg_wr) begin
      case (reg_addr)
        REG_STATUS: program_status_word_d = reg_wdata;
        REG_STACK: stack_pointer_d = reg_wdata;
        REG_PAGE: xram_page_control_d = reg_wdata;
        default: program_status_word_d = program_status_word_q;
      endcase
    end

    // Reads show the value before this cycle's update; unmapped is zero.
    if (reg_rd) begin
      case (reg_addr)
        REG_STATUS: reg_rdata_d = program_status_word_q;
        REG_STACK: reg_rdata_d = stack_pointer_q;
        REG_PAGE: reg_rdata_d = xram_page_control_q;
        default: reg_rdata_d = RDATA_IDLE;
      endcase
    end

    // The bank output follows the status word on the same edge.
    bank_d = {program_status_word_d[STATUS_BANK_HI],
              program_status_word_d[STATUS_BANK_LO]};         // [RQ2]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; reset restores the pointer and nothing in memory.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stack_pointer_q <= STACK_RESET;                         // [RQ9] [RQ11]
      program_status_word_q <= STATUS_RESET;
      xram_page_control_q <= PAGE_RESET;
      bank_q <= 2'b00;
      reg_rdata_q <= RDATA_IDLE;
      op_done_q <= 1'b0;
      op_rdata_q <= RDATA_IDLE;
      op_rbit_q <= 1'b0;
      op_bad_q <= 1'b0;
    end else begin
      stack_pointer_q <= stack_pointer_d;
      program_status_word_q <= program_status_word_d;
      xram_page_control_q <= xram_page_control_d;
      bank_q <= bank_d;
      reg_rdata_q <= reg_rdata_d;
      op_done_q <= op_done_d;
      op_rdata_q <= op_rdata_d;
      op_rbit_q <= op_rbit_d;
      op_bad_q <= op_bad_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal memory has no reset branch: data survives any reset, which
  // also keeps 2048 flops off the reset tree.
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      idata_q[mem_idx] <= mem_wd;                             // [RQ11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External-data RAM.
  cdm_xram #(
    .DEPTH(XRAM_BYTES),
    .AW(XA_W)
  ) u_xram (
    .mclk(mclk),
    .bus(xbus.slave)
  );

endmodule : cdm_data_map

// *** hw/cdm_pkg.sv ***
// Constants, register offsets and operation codes for the core data map.
// Assumes a single system clock and a synchronous active-high reset.
package cdm_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Data widths and memory sizes.
  localparam int unsigned DATA_W = 8;
  localparam int unsigned IDATA_BYTES = 256;
  localparam int unsigned XRAM_BYTES_DEF = 1024;
  localparam int unsigned REG_ADDR_W = 4;

  //////////////////////////////////////////////////////////////////////////
  // Register offsets on the plain register port.
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_STACK = 4'h1;
  localparam logic [3:0] REG_PAGE = 4'h2;

  //////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] STACK_RESET = 8'h07;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // Field positions and fixed regions of internal data memory.
  localparam int unsigned STATUS_BANK_LO = 3;
  localparam int unsigned STATUS_BANK_HI = 4;
  localparam int unsigned BIT_ADDR_HI = 7;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] STACK_STEP = 8'h01;
  localparam logic [7:0] BIT_ONE = 8'h01;

  //////////////////////////////////////////////////////////////////////////
  // Operations issued by the execution unit, one per cycle.
  typedef enum logic [3:0] {
    OP_NONE,
    OP_DIR_RD,
    OP_DIR_WR,
    OP_BIT_RD,
    OP_BIT_WR,
    OP_REG_RD,
    OP_REG_WR,
    OP_IND_RD,
    OP_IND_WR,
    OP_PUSH,
    OP_POP,
    OP_XDP_RD,
    OP_XDP_WR,
    OP_XRI_RD,
    OP_XRI_WR
  } cdm_op_t;

endpackage : cdm_pkg

// *** hw/cdm_xram_if.sv ***
// Port bundle between the data map and its external-data RAM.
// Assumes the RAM answers reads combinationally in the same cycle.
`timescale 1ns/100ps
interface cdm_xram_if #(
  parameter int unsigned AW = 10
) ();
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport master (output we, output addr, output wdata, input rdata);
  modport slave (input we, input addr, input wdata, output rdata);
endinterface : cdm_xram_if

// *** hw/cdm_xram.sv ***
// External-data RAM built from flip-flops, addressed by an index.
// Assumes the master holds address and write data stable in the cycle.
`timescale 1ns/100ps
module cdm_xram #(
  parameter int unsigned DEPTH = 1024,
  parameter int unsigned AW = 10
) (
  // Clock.
  input wire logic mclk,
  // Access port.
  cdm_xram_if.slave bus
);

  ////////////////////////////////////////////////////////////////////////////
  // The address must reach exactly every byte, or aliasing breaks.
  if (DEPTH != (1 << AW)) begin : g_bad_depth
    $error("cdm_xram: DEPTH must equal 2**AW");
  end

  logic [7:0] mem_q [DEPTH];

  // Contents carry no reset, so a system reset leaves data intact.
  always_ff @(posedge mclk) begin
    if (bus.we) begin
      mem_q[bus.addr] <= bus.wdata;
    end
  end

  // Read data follows the address in the same cycle.
  assign bus.rdata = mem_q[bus.addr];

endmodule : cdm_xram

// *** tb/cdm_data_map_asserts.sv ***
// Checker on the data map top ports.
// Assumes one clock mclk and a synchronous active-high sys_rst.
`timescale 1ns/100ps
module cdm_data_map_asserts
  import cdm_pkg::*;
#(
  parameter int unsigned XRAM_BYTES = XRAM_BYTES_DEF
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  // Operations.
  input cdm_op_t op_code,
  input wire logic [7:0] op_addr,
  input wire logic op_done_q,
  input wire logic op_rbit_q,
  input wire logic op_bad_q,
  input wire logic [1:0] bank_q,
  input wire logic [7:0] stack_pointer_q
);
  // Decoded causes; a register write to the pointer beats push and pop.
  logic bit_op;
  logic stack_wr;
  logic status_wr;
  logic [1:0] wr_bank;
  assign bit_op = (op_code == OP_BIT_RD) || (op_code == OP_BIT_WR);
  assign stack_wr = reg_wr && (reg_addr == REG_STACK);
  assign status_wr = reg_wr && (reg_addr == REG_STATUS);
  assign wr_bank = reg_wdata[STATUS_BANK_HI:STATUS_BANK_LO];

  //////////////////////////////////////////////////////////////////////
  // All checks share the one clock and reset.
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  stack_reset_a: assert property ($fell(sys_rst) |->
    stack_pointer_q == STACK_RESET && bank_q == 2'b00)
    else $error("stack reset");
  push_inc_a: assert property (op_code == OP_PUSH && !stack_wr |=>
    stack_pointer_q == $past(stack_pointer_q) + STACK_STEP)
    else $error("push");
  pop_dec_a: assert property (op_code == OP_POP && !stack_wr |=>
    stack_pointer_q == $past(stack_pointer_q) - STACK_STEP)
    else $error("pop");
  stack_hold_a: assert property (!stack_wr && op_code != OP_PUSH &&
    op_code != OP_POP |=> $stable(stack_pointer_q)) else $error("stack moved");
  bank_sel_a: assert property (status_wr |=>
    bank_q == $past(wr_bank)) else $error("bank select");
  bad_bit_a: assert property (bit_op && op_addr[BIT_ADDR_HI] |=>
    op_bad_q && op_done_q && $stable(op_rbit_q)) else $error("bad bit");
  good_bit_a: assert property (bit_op && !op_addr[BIT_ADDR_HI] |=>
    op_done_q && !op_bad_q) else $error("good bit");
  rbit_hold_a: assert property (op_code != OP_BIT_RD |=>
    $stable(op_rbit_q)) else $error("bit moved");
  stack_read_a: assert property (reg_rd && reg_addr == REG_STACK |=>
    reg_rdata_q == $past(stack_pointer_q)) else $error("stack read");

  // Main scenarios reached.
  cover property (op_code == OP_PUSH ##1 op_done_q);
  cover property (op_bad_q);
  cover property ($fell(sys_rst));
  cover property (op_code == OP_XRI_RD ##1 op_done_q);
endmodule : cdm_data_map_asserts

bind cdm_data_map cdm_data_map_asserts #(.XRAM_BYTES(XRAM_BYTES)) u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .op_code(op_code), .op_addr(op_addr),
  .op_done_q(op_done_q), .op_rbit_q(op_rbit_q), .op_bad_q(op_bad_q),
  .bank_q(bank_q), .stack_pointer_q(stack_pointer_q));

// *** tb/cdm_exec_model.sv ***
// Execution-unit model: issues one operation at a time.
// Assumes the data map answers with op_done_q the cycle after the take.
`timescale 1ns/100ps
module cdm_exec_model
  import cdm_pkg::*;
(
  // Clock and answer.
  input wire logic mclk,
  input wire logic op_done_q,
  // Operation request.
  output cdm_op_t op_code,
  output logic [7:0] op_addr,
  output logic [2:0] op_reg,
  output logic [7:0] op_wdata,
  output logic op_wbit,
  output logic [15:0] op_xptr
);
  // Idle until asked.
  initial begin
    op_code = OP_NONE;
    {op_addr, op_reg, op_wdata, op_wbit, op_xptr} = '0;
  end

  //////////////////////////////////////////////////////////////////////
  // One cycle of request; qualifiers are inverted afterwards so the map
  // cannot lean on stale operands.
  task automatic issue(input cdm_op_t c, input logic [7:0] a,
      input logic [2:0] r, input logic [7:0] d, input logic [15:0] p,
      output logic ok);
    @(posedge mclk);
    op_code <= c;
    {op_addr, op_reg, op_wdata, op_wbit, op_xptr} <= {a, r, d, d[0], p};
    @(posedge mclk);
    op_code <= OP_NONE;
    {op_addr, op_reg, op_wdata, op_wbit, op_xptr} <= ~{a, r, d, d[0], p};
    ok = 1'b0;
    for (int i = 0; i < 3 && !ok; i++) begin
      #1;
      ok = (op_done_q === 1'b1);
      if (!ok) @(posedge mclk);
    end
  endtask : issue
endmodule : cdm_exec_model

// *** tb/cdm_data_map_test.sv ***
// Testbench for the data map: register and operation sequences.
// Assumes the execution-unit model drives the operation port.
`timescale 1ns/100ps
module cdm_data_map_test
  import cdm_pkg::*;
();
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata_q, op_addr, op_wdata, op_rdata_q, stack_pointer_q;
  cdm_op_t op_code;
  logic [2:0] op_reg;
  logic op_wbit, op_done_q, op_rbit_q, op_bad_q, ok;
  logic [15:0] op_xptr;
  logic [1:0] bank_q;
  int err_count = 0;
  int n_compared = 0;

  // Clock at 100 MHz.
  always #5 mclk = ~mclk;

  cdm_data_map #(.XRAM_BYTES(1024)) DUT (.mclk(mclk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .op_code(op_code),
    .op_addr(op_addr), .op_reg(op_reg), .op_wdata(op_wdata),
    .op_wbit(op_wbit), .op_xptr(op_xptr), .op_done_q(op_done_q),
    .op_rdata_q(op_rdata_q), .op_rbit_q(op_rbit_q), .op_bad_q(op_bad_q),
    .bank_q(bank_q), .stack_pointer_q(stack_pointer_q));
  cdm_exec_model cpu (.mclk(mclk), .op_done_q(op_done_q),
    .op_code(op_code), .op_addr(op_addr), .op_reg(op_reg),
    .op_wdata(op_wdata), .op_wbit(op_wbit), .op_xptr(op_xptr));

  //////////////////////////////////////////////////////////////////////
  // Verdict and compare.
  task automatic end_of_test();
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string w, input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", w, e, s);
    end
  endtask : chk

  // Register port: one-cycle strobes, read data the cycle after.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk);
    {reg_wr, reg_wdata} <= {1'b0, ~d};
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e, string w);
    @(posedge mclk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(w, reg_rdata_q, e);
  endtask : rd

  // An operation; a missing answer ends the run.
  task automatic op(input cdm_op_t c, input logic [7:0] a,
      input logic [2:0] r, input logic [7:0] d, input logic [15:0] p);
    cpu.issue(c, a, r, d, p, ok);
    if (!ok) begin
      err_count++;
      end_of_test();
    end
  endtask : op

  task automatic opr(input cdm_op_t c, input logic [7:0] a,
      input logic [2:0] r, input logic [15:0] p, input logic [7:0] e);
    op(c, a, r, 8'h00, p);
    chk("rdata", op_rdata_q, e);
  endtask : opr

  // Main sequence.
  initial begin
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(REG_STACK, 8'h07, "stack");
    op(OP_PUSH, 8'h00, 3'h0, 8'h55, 16'h0);
    chk("stack", stack_pointer_q, 8'h08);
    opr(OP_DIR_RD, 8'h08, 3'h0, 16'h0, 8'h55);
    // Other status bits set must not disturb the bank choice.
    for (int b = 0; b < 4; b++) begin
      wr(REG_STATUS, {3'b111, 2'(b), 3'b111});
      chk("bank", {6'h00, bank_q}, 8'(b));
      op(OP_REG_WR, 8'h00, 3'(b + 3), 8'ha0 + 8'(b), 16'h0);
      opr(OP_DIR_RD, 8'(9 * b + 3), 3'h0, 16'h0, 8'ha0 + 8'(b));
    end
    wr(REG_STATUS, 8'h08);
    opr(OP_REG_RD, 8'h00, 3'h0, 16'h0, 8'h55);
    wr(REG_STATUS, 8'h10);
    op(OP_REG_WR, 8'h00, 3'h1, 8'h40, 16'h0);
    op(OP_REG_WR, 8'h00, 3'h0, 8'h41, 16'h0);
    op(OP_DIR_WR, 8'h40, 3'h0, 8'h5a, 16'h0);
    opr(OP_IND_RD, 8'h00, 3'h7, 16'h0, 8'h5a);
    op(OP_IND_WR, 8'h00, 3'h0, 8'hc3, 16'h0);
    opr(OP_DIR_RD, 8'h41, 3'h0, 16'h0, 8'hc3);
    // Bit area in the middle and at its top end.
    op(OP_DIR_WR, 8'h22, 3'h0, 8'h00, 16'h0);
    op(OP_BIT_WR, 8'h13, 3'h0, 8'h01, 16'h0);
    opr(OP_DIR_RD, 8'h22, 3'h0, 16'h0, 8'h08);
    op(OP_DIR_WR, 8'h2f, 3'h0, 8'h7f, 16'h0);
    op(OP_BIT_WR, 8'h7f, 3'h0, 8'h01, 16'h0);
    op(OP_BIT_WR, 8'h7e, 3'h0, 8'h00, 16'h0);
    opr(OP_DIR_RD, 8'h2f, 3'h0, 16'h0, 8'hbf);
    op(OP_BIT_RD, 8'h7f, 3'h0, 8'h00, 16'h0);
    chk("rbit", {7'h00, op_rbit_q}, 8'h01);
    op(OP_BIT_WR, 8'h80, 3'h0, 8'h01, 16'h0);
    chk("bad", {7'h00, op_bad_q}, 8'h01);
    // Stack wraps through the top of the 256 bytes.
    wr(REG_STACK, 8'hfe);
    op(OP_PUSH, 8'h00, 3'h0, 8'h11, 16'h0);
    op(OP_PUSH, 8'h00, 3'h0, 8'h22, 16'h0);
    chk("stack", stack_pointer_q, 8'h00);
    opr(OP_POP, 8'h00, 3'h0, 16'h0, 8'h22);
    opr(OP_DIR_RD, 8'hff, 3'h0, 16'h0, 8'h11);
    // External RAM through the wide pointer and through the page.
    op(OP_XDP_WR, 8'h00, 3'h0, 8'h3c, 16'h0400);
    opr(OP_XDP_RD, 8'h00, 3'h0, 16'h0000, 8'h3c);
    op(OP_XDP_WR, 8'h00, 3'h0, 8'h96, 16'h03ff);
    opr(OP_XDP_RD, 8'h00, 3'h0, 16'hffff, 8'h96);
    wr(REG_PAGE, 8'h02);
    rd(REG_PAGE, 8'h02, "page");
    wr(REG_STATUS, 8'h00);
    op(OP_REG_WR, 8'h00, 3'h1, 8'h10, 16'h0);
    op(OP_XRI_WR, 8'h00, 3'h1, 8'h77, 16'h0);
    opr(OP_XRI_RD, 8'h00, 3'h1, 16'h0, 8'h77);
    opr(OP_XDP_RD, 8'h00, 3'h0, 16'h0210, 8'h77);
    // Second reset: memory keeps, pointer returns.
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(REG_STACK, 8'h07, "stack");
    opr(OP_DIR_RD, 8'hff, 3'h0, 16'h0, 8'h11);
    opr(OP_XDP_RD, 8'h00, 3'h0, 16'h0400, 8'h3c);
    rd(4'hf, 8'h00, "unmapped");
    end_of_test();
  end
endmodule : cdm_data_map_test
